// file: core/pin_power_down_hold.sv
/*
 * Pin-controlled power-down of a small programmable logic device.
 * Freezes the outputs, blocks and holds the inputs and asks the logic
 * array to hold its state while the power-down pin is high.
 * Assumes all pin inputs and the option strap are asynchronous and
 * are synchronised here; array-side inputs are on clk_sys.
 */
//
// Overview of operation
// - Power-down exists only when the option is selected; then the pin controls it.
// - Pin high with the option on puts the device into low power.
// - During power-down all outputs and internal state are held unchanged.
// - An output tri-stated at entry stays tri-stated throughout power-down.
// - During power-down all inputs except the power-down pin are blocked.
// - Hold latches keep input and I/O levels during power-down.
// - With the option on, the pin's array input is unavailable.
// - After the pin falls, allow up to 1 us before anything is valid again.
`timescale 1ns/1ns
`include "pd_regs.svh"

module pin_power_down_hold
   import pd_pkg::*;
(
   input  wire logic                   clk_sys,          // System clock, 50 MHz
   input  wire logic                   srst,             // Synchronous reset
   input  wire logic                   cfg_pd_enable,    // Option strap, caught after reset release
   input  wire logic                   power_down_pin_in,// Power-down pin level
   input  wire pin_sense_t             pin_in,           // Input and I/O pin levels
   input  wire pin_drive_t             core_drive,       // Drive from the logic array
   input  wire logic                   core_pd_level,    // Array drive of the pin
   input  wire logic                   core_pd_oe,       // Array enable of the pin
   output pin_drive_t                  pin_drive,        // Drive to the I/O pins
   output pin_sense_t                  array_in,         // Inputs seen by the array
   output logic                        array_pd_in,      // Pin level seen by the array
   output logic                        power_down_pin_out,// Pin output level
   output logic                        power_down_pin_oe,// Pin output enable
   output logic                        array_hold,       // Array holds its state
   output logic                        low_power,        // Device in low power
   output logic                        pd_option         // Option in force
);

   localparam int SENSE_W = `PD_NUM_IO + `PD_NUM_DED;
   localparam int DRIVE_W = 2 * `PD_NUM_IO;
   localparam logic [`PD_WAKE_CNT_W-1:0] WAKE_LAST =
      `PD_WAKE_CNT_W'(`PD_WAKE_CYC - 1);

   // Synchronisers
   logic             pd_meta;
   logic             pd_sync;
   logic             cfg_meta;
   logic             cfg_sync;
   pin_sense_t       sense_meta;
   pin_sense_t       sense_sync;

   always_ff @(posedge clk_sys) begin
      pd_meta    <= power_down_pin_in;
      pd_sync    <= pd_meta;
      cfg_meta   <= cfg_pd_enable;
      cfg_sync   <= cfg_meta;
      sense_meta <= pin_in;
      sense_sync <= sense_meta;
   end

   // Option strap, taken on the first edge after reset release
   logic             rst_seen;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rst_seen  <= 1'h1;
         pd_option <= `PD_RST_OPTION;
      end else if (rst_seen) begin
         rst_seen  <= 1'h0;
         pd_option <= cfg_sync;
      end
   end

   // Power-down request
   wire logic        pd_request;

   assign pd_request = pd_option & pd_sync;

   // Sequence
   pd_state_t                   state;
   pd_state_t                   next_state;
   logic [`PD_WAKE_CNT_W-1:0]   wake_cnt;
   logic [`PD_WAKE_CNT_W-1:0]   next_wake_cnt;
   wire logic                   wake_done;

   assign wake_done = (wake_cnt == WAKE_LAST);

   always_comb begin
      next_state    = state;
      next_wake_cnt = wake_cnt;
      unique case (state)
         ST_RUN: begin
            next_wake_cnt = '0;
            if (pd_request) begin
               next_state = ST_DOWN;
            end
         end
         ST_DOWN: begin
            next_wake_cnt = '0;
            if (!pd_request) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (pd_request) begin
               next_state    = ST_DOWN;
               next_wake_cnt = '0;
            end else if (wake_done) begin
               next_state    = ST_RUN;
               next_wake_cnt = '0;
            end else begin
               next_wake_cnt = wake_cnt + 1'h1;
            end
         end
         default: begin
            next_state    = ST_RUN;
            next_wake_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state    <= ST_RUN;
         wake_cnt <= '0;
      end else begin
         state    <= next_state;
         wake_cnt <= next_wake_cnt;
      end
   end

   // Hold while down and while recovering
   wire logic        next_hold;
   wire logic        next_low_power;

   assign next_hold      = (next_state != ST_RUN);
   assign next_low_power = (next_state == ST_DOWN);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         array_hold <= 1'h0;
         low_power  <= 1'h0;
      end else begin
         array_hold <= next_hold;
         low_power  <= next_low_power;
      end
   end

   // Output freeze, enables included
   wire logic [DRIVE_W-1:0] drive_live;
   logic      [DRIVE_W-1:0] drive_held;

   assign drive_live = core_drive;

   pin_hold_keeper #(
      .W       (DRIVE_W)
   ) u_drive_keep (
      .clk_sys (clk_sys),
      .srst    (srst),
      .hold    (next_hold),
      .d       (drive_live),
      .q       (drive_held)
   );

   assign pin_drive = drive_held;

   // Input blocking and hold latches
   wire logic [SENSE_W-1:0] sense_live;
   logic      [SENSE_W-1:0] sense_held;

   assign sense_live = sense_sync;

   pin_hold_keeper #(
      .W       (SENSE_W)
   ) u_sense_keep (
      .clk_sys (clk_sys),
      .srst    (srst),
      .hold    (next_hold),
      .d       (sense_live),
      .q       (sense_held)
   );

   assign array_in = sense_held;

   // Power-down pin as ordinary I/O when the option is off
   wire logic        next_pd_in;
   wire logic        next_pd_oe;
   wire logic        next_pd_out;

   assign next_pd_in  = pd_option ? 1'h0 : pd_sync;
   assign next_pd_oe  = pd_option ? 1'h0 : core_pd_oe;
   assign next_pd_out = pd_option ? 1'h0 : core_pd_level;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         array_pd_in        <= 1'h0;
         power_down_pin_oe  <= `PD_RST_DRIVE;
         power_down_pin_out <= `PD_RST_DRIVE;
      end else begin
         array_pd_in        <= next_pd_in;
         power_down_pin_oe  <= next_pd_oe;
         power_down_pin_out <= next_pd_out;
      end
   end

   // Entry timing on the driver side: inputs pass the same two stages
   // as the pin, so the captured values are those before the rise

endmodule

// file: core/pd_regs.svh
/*
 * Constants of the pin-controlled power-down block: pin counts,
 * reset values and timing counts.
 * Assumes a 50 MHz system clock; included by its bare name.
 */
`ifndef PD_REGS_SVH
`define PD_REGS_SVH

// Pin counts of the device
`define PD_NUM_IO          32
`define PD_NUM_DED         4

// Clock period in ns
`define PD_CLK_PERIOD_NS   20

// Recovery time after the power-down pin falls, in us
`define PD_T_WAKE_US       1
// Longest time, so round down, never below one cycle
`define PD_WAKE_CYC        (((`PD_T_WAKE_US * 1000) / `PD_CLK_PERIOD_NS) < 1 ? 1 : \
                            ((`PD_T_WAKE_US * 1000) / `PD_CLK_PERIOD_NS))
`define PD_WAKE_CNT_W      8

// Reset values
`define PD_RST_OPTION      1'h0
`define PD_RST_DRIVE       1'h0

`endif

// file: core/pd_pkg.sv
/*
 * Types of the pin-controlled power-down block.
 * Assumes pd_regs.svh is on the include path.
 */
`include "pd_regs.svh"

package pd_pkg;

   // Output drive of the user I/O pins
   typedef struct packed {
      logic [`PD_NUM_IO-1:0] level;
      logic [`PD_NUM_IO-1:0] oe;
   } pin_drive_t;

   // Levels seen on the device inputs
   typedef struct packed {
      logic [`PD_NUM_IO-1:0]  io;
      logic [`PD_NUM_DED-1:0] ded;
   } pin_sense_t;

   // Power-down sequence, one-hot
   typedef enum logic [2:0] {
      ST_RUN  = 3'h1,
      ST_DOWN = 3'h2,
      ST_WAKE = 3'h4
   } pd_state_t;

endpackage

// file: core/pin_hold_keeper.sv
/*
 * Bank of per-bit hold latches: each bit follows its source while
 * hold is low and keeps its last value while hold is high.
 * Assumes the source is already on the clk_sys domain.
 */
`timescale 1ns/1ns

module pin_hold_keeper #(
   parameter int W = 8                     // Number of bits
) (
   input  wire logic         clk_sys,      // System clock
   input  wire logic         srst,         // Synchronous reset
   input  wire logic         hold,         // Keep current value
   input  wire logic [W-1:0] d,            // Live value
   output logic      [W-1:0] q             // Held or live value
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         wire logic next_q;
         assign next_q = hold ? q[i] : d[i];
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               q[i] <= 1'h0;
            end else begin
               q[i] <= next_q;
            end
         end
      end
   endgenerate

endmodule

// file: sim/pd_checker_assertions.sv
/* Port checker of pin_power_down_hold.
   Assumes one clock domain; bound after the module. */
`timescale 1ns/1ns
module pd_checker import pd_pkg::*; (
   input wire logic       clk_sys,           // Clock
   input wire logic       srst,              // Reset
   input wire logic       power_down_pin_in, // Pin
   input wire pin_drive_t core_drive,        // Array drive
   input wire pin_drive_t pin_drive,         // Pin drive
   input wire pin_sense_t array_in,          // Array inputs
   input wire logic       array_pd_in,       // Pin to array
   input wire logic       power_down_pin_oe, // Pin enable
   input wire logic       array_hold,        // Hold
   input wire logic       low_power,         // Low power
   input wire logic       pd_option          // Option
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic [7:0] wake_cnt;
   // Cycles spent in recovery
   always_ff @(posedge clk_sys) begin
      wake_cnt <= (srst || !array_hold || low_power) ? 8'h00 : wake_cnt + 8'h01;
   end
   sequence pin_up;
      pd_option && $rose(power_down_pin_in);
   endsequence
   sequence pin_dn;
      pd_option && low_power && $fell(power_down_pin_in);
   endsequence
   enter_low_a: assert property (pin_up |-> ##[2:4] low_power)
      else $error("no entry");
   exit_low_a: assert property (pin_dn |-> ##[2:4] !low_power && array_hold)
      else $error("no wake");
   option_gate_a: assert property (!pd_option |-> !array_hold)
      else $error("hold without option");
   low_hold_a: assert property (low_power |-> array_hold)
      else $error("low power without hold");
   drive_freeze_a: assert property (
      array_hold && $past(array_hold) |-> $stable(pin_drive)) else $error("drive moved");
   input_block_a: assert property (
      array_hold && $past(array_hold) |-> $stable(array_in)) else $error("input moved");
   pd_hidden_a: assert property (
      pd_option && $past(pd_option) |-> !array_pd_in && !power_down_pin_oe)
      else $error("pin not hidden");
   drive_pass_a: assert property (
      !array_hold && !$past(array_hold) && !$past(srst) |-> pin_drive == $past(core_drive))
      else $error("drive not passed");
   wake_len_a: assert property (
      $fell(array_hold) |-> wake_cnt >= 8'h30 && wake_cnt <= 8'h34) else $error("wake length");
endmodule
bind pin_power_down_hold pd_checker chk_u (.clk_sys(clk_sys), .srst(srst),
   .power_down_pin_in(power_down_pin_in), .core_drive(core_drive), .pin_drive(pin_drive),
   .array_in(array_in), .array_pd_in(array_pd_in), .power_down_pin_oe(power_down_pin_oe),
   .array_hold(array_hold), .low_power(low_power), .pd_option(pd_option));

// file: sim/pd_system_model.sv
/* Far-side system logic: drives the power-down pin and input pins.
   Assumes requests change at the falling edge of clk_sys. */
`timescale 1ns/1ns
module pd_system_model import pd_pkg::*; (
   input  wire logic       clk_sys,           // Clock
   input  wire logic       down_req,          // Ask for power-down
   input  wire pin_sense_t in_req,            // Wanted pin levels
   output logic            power_down_pin_in, // Pin
   output pin_sense_t      pin_in             // Input pins
);
   logic [1:0] settle = 2'h0;
   logic       down_q = 1'b0;
   pin_sense_t in_q = '0;
   initial power_down_pin_in = 1'b0;
   initial pin_in = '0;
   // Requests taken at the rising edge, clear of the bench's falling-edge writes
   always @(posedge clk_sys) begin
      down_q <= down_req;
      in_q <= in_req;
   end
   always @(negedge clk_sys) begin
      if (settle != 2'h0)
         settle <= settle - 2'h1; // inputs kept 60 ns after the rise
      else if (down_q && !power_down_pin_in) begin
         power_down_pin_in <= 1'b1; // inputs steady 20 ns before
         settle <= 2'h2;
      end else begin
         power_down_pin_in <= down_q;
         pin_in <= in_q;
      end
   end
endmodule

// file: sim/tb.sv
/* Testbench of pin_power_down_hold.
   Assumes pd_system_model drives the pins. */
`timescale 1ns/1ns
module tb;
   import pd_pkg::*;
   logic       clk_sys = 1'b0;
   logic       srst = 1'b1;
   logic       cfg_pd_enable = 1'b0;
   logic       down_req = 1'b0;
   logic       core_pd_level = 1'b0;
   logic       core_pd_oe = 1'b0;
   pin_sense_t in_req = '0;
   pin_drive_t core_drive = '0;
   pin_sense_t pin_in, array_in;
   pin_drive_t pin_drive;
   logic       power_down_pin_in, array_pd_in, power_down_pin_out, power_down_pin_oe;
   logic       array_hold, low_power, pd_option;
   int         error_cnt = 0;
   int         total_checks = 0;
   int         i;
   always #10 clk_sys = ~clk_sys;
   pd_system_model sys_u (.clk_sys(clk_sys), .down_req(down_req), .in_req(in_req),
      .power_down_pin_in(power_down_pin_in), .pin_in(pin_in));
   pin_power_down_hold dut_u (.clk_sys(clk_sys), .srst(srst), .cfg_pd_enable(cfg_pd_enable),
      .power_down_pin_in(power_down_pin_in), .pin_in(pin_in), .core_drive(core_drive),
      .core_pd_level(core_pd_level), .core_pd_oe(core_pd_oe), .pin_drive(pin_drive),
      .array_in(array_in), .array_pd_in(array_pd_in), .power_down_pin_out(power_down_pin_out),
      .power_down_pin_oe(power_down_pin_oe), .array_hold(array_hold), .low_power(low_power),
      .pd_option(pd_option));
   task automatic chk(input bit ok, input string m);
      total_checks++;
      if (!ok) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d, checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic do_reset(input logic strap);
      cfg_pd_enable = strap;
      srst = 1'b1;
      tick(3);
      srst = 1'b0;
      tick(2);
      chk(pd_option === strap, "option strap");
   endtask
   task automatic t_plain_io();
      do_reset(1'b0);
      core_pd_level = 1'b1;
      core_pd_oe = 1'b1;
      down_req = 1'b1;
      tick(8);
      chk(power_down_pin_oe === 1'b1 && power_down_pin_out === 1'b1, "pin out");
      chk(array_pd_in === 1'b1 && low_power === 1'b0, "pin in");
      down_req = 1'b0;
      core_pd_oe = 1'b0;
      tick(8);
      chk(array_pd_in === 1'b0 && power_down_pin_oe === 1'b0, "pin idle");
   endtask
   task automatic t_freeze();
      pin_drive_t held = {32'hA5A5_0F0F, 32'hFFFF_0000};
      pin_sense_t seen = {32'h1234_5678, 4'h9};
      do_reset(1'b1);
      core_drive = held;
      in_req = seen;
      tick(4);
      down_req = 1'b1;
      for (i = 0; i < 8 && low_power !== 1'b1; i++) tick(1);
      chk(low_power === 1'b1 && array_hold === 1'b1, "entry");
      core_drive = ~held;
      in_req = ~seen;
      tick(6);
      chk(pin_drive === held, "outputs held");
      chk(array_in === seen, "inputs blocked");
      chk(array_pd_in === 1'b0 && power_down_pin_oe === 1'b0 && power_down_pin_out === 1'b0,
          "pin hidden");
      down_req = 1'b0;
      for (i = 0; i < 8 && low_power !== 1'b0; i++) tick(1);
      chk(array_hold === 1'b1 && array_in === seen, "wake");
      for (i = 0; i < 60 && array_hold !== 1'b0; i++) tick(1);
      chk(i >= 45 && i <= 52, "recovery time");
      tick(5);
      chk(pin_drive === ~held && array_in === ~seen, "live again");
   endtask
   task automatic t_rewake();
      down_req = 1'b1;
      for (i = 0; i < 8 && low_power !== 1'b1; i++) tick(1);
      down_req = 1'b0;
      tick(20);
      down_req = 1'b1;
      tick(8);
      chk(low_power === 1'b1 && array_hold === 1'b1, "back down");
      down_req = 1'b0;
      tick(40);
      chk(array_hold === 1'b1, "recovery restarted");
      tick(30);
      chk(array_hold === 1'b0, "hold left");
   endtask
   initial begin
      t_plain_io();
      t_freeze();
      t_rewake();
      wrap_up();
   end
   initial begin
      #100000;
      error_cnt++;
      wrap_up();
   end
endmodule
